//--- src/cstrim_pkg.sv
/*
 Constants for the current-sense trim register bank: offsets, field
 positions, masks and reset values.
 Assumes a classic Wishbone slave with 32-bit data, one register per word.
*/
package cstrim_pkg;
   localparam logic [3:0] CSTRIM_AC_OFS      = 4'h0;
   localparam logic [3:0] CSTRIM_DC_OFS      = 4'h4;
   localparam logic [3:0] CSTRIM_ZC_OFS      = 4'h8;
   // Writable and readable bits per register
   localparam logic [7:0] CSTRIM_AC_MASK     = 8'h7F;
   localparam logic [7:0] CSTRIM_DC_MASK     = 8'h8F;
   localparam logic [7:0] CSTRIM_ZC_MASK     = 8'hFF;
   localparam int         CSTRIM_DC_EN_BIT   = 7;
   // Values after reset (unknown bits given zero, offset at midscale)
   localparam logic [7:0] CSTRIM_AC_RST      = 8'h00;
   localparam logic [7:0] CSTRIM_DC_RST      = 8'h00;
   localparam logic [7:0] CSTRIM_ZC_RST      = 8'h80;
endpackage

//--- src/cstrim_regs.sv
/*
 Current-sense trim register bank: three 8-bit registers on Wishbone,
 driving static code buses to the analog sense chain.
 Assumes a classic Wishbone master on the same clock; ack after one cycle.
*/
`timescale 1ns/100ps
module cstrim_regs
   import cstrim_pkg::*;
#(
   // Bus widths; every register sits in byte lane 0 of its own word
   parameter int DATA_W = 32,
   parameter int ADR_W  = 4
)
(
   // Clock and reset
   input  wire logic                  clk_sys_i,
   input  wire logic                  rst_b_i,
   // Wishbone slave
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [ADR_W-1:0]      wb_adr_i,
   input  wire logic [DATA_W/8-1:0]   wb_sel_i,
   input  wire logic [DATA_W-1:0]     wb_dat_i,
   output logic      [DATA_W-1:0]     wb_dat_o,
   output logic                       wb_ack_o,
   output logic                       wb_err_o,
   // Analog code outputs
   output logic      [3:0]  ac_gain_code_o,
   output logic      [2:0]  dc_gain_code_o,
   output logic             dc_gain_loop_enable_o,
   output logic      [7:0]  zero_current_offset_code_o
);
   // Zero padding above the byte lane on the read path
   localparam int PAD_W = DATA_W - 8;

   // Register contents, each with its next value
   logic [7:0]        ac_reg;
   logic [7:0]        ac_next;
   logic [7:0]        dc_reg;
   logic [7:0]        dc_next;
   logic [7:0]        zc_reg;
   logic [7:0]        zc_next;
   // Bus answer state
   logic              ack_reg;
   logic              ack_next;
   logic              err_reg;
   logic              err_next;
   logic [DATA_W-1:0] rd_reg;
   logic [DATA_W-1:0] rd_next;
   // Request decode
   logic              req;
   logic              hit_ac;
   logic              hit_dc;
   logic              hit_zc;
   logic              mapped;
   logic              wr_b0;
   logic              rd_req;

   // Elaboration check: a wider byte lane and four offset bits must fit
   if (DATA_W < 16 || (DATA_W % 8) != 0 || ADR_W < 4) begin : g_bad_width
      $error("cstrim_regs needs DATA_W a multiple of 8 of at least 16 and ADR_W of at least 4");
   end

   // Request decode; a new request only when no answer is pending,
   // so the edge that shows ack never takes the held request twice
   assign req    = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
   assign hit_ac = (wb_adr_i == ADR_W'(CSTRIM_AC_OFS));
   assign hit_dc = (wb_adr_i == ADR_W'(CSTRIM_DC_OFS));
   assign hit_zc = (wb_adr_i == ADR_W'(CSTRIM_ZC_OFS));
   assign mapped = hit_ac | hit_dc | hit_zc;
   assign wr_b0  = req & wb_we_i & wb_sel_i[0]; // Only lane 0 carries a register
   assign rd_req = req & ~wb_we_i;

   // Next register contents; unimplemented bits never get storage
   always_comb begin
      ac_next = ac_reg;
      dc_next = dc_reg;
      zc_next = zc_reg;
      if (wr_b0 && hit_ac) begin
         ac_next = wb_dat_i[7:0] & CSTRIM_AC_MASK;
      end
      if (wr_b0 && hit_dc) begin
         dc_next = wb_dat_i[7:0] & CSTRIM_DC_MASK;
      end
      if (wr_b0 && hit_zc) begin
         zc_next = wb_dat_i[7:0] & CSTRIM_ZC_MASK;
      end
   end

   // Register contents; reset leaves the loop enable clear, offset midscale
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ac_reg <= CSTRIM_AC_RST;
         dc_reg <= CSTRIM_DC_RST;
         zc_reg <= CSTRIM_ZC_RST;
      end else begin
         ac_reg <= ac_next;
         dc_reg <= dc_next;
         zc_reg <= zc_next;
      end
   end

   // Next bus answer: ack for mapped words, err for holes, read data
   // only with the answer so the data bus idles at zero
   always_comb begin
      ack_next = 1'b0;
      err_next = 1'b0;
      rd_next  = '0;
      if (req) begin
         ack_next = mapped;
         err_next = ~mapped; // Holes are refused, nothing written
      end
      if (rd_req) begin
         if (hit_ac) begin
            rd_next = {{PAD_W{1'b0}}, ac_reg & CSTRIM_AC_MASK};
         end else if (hit_dc) begin
            rd_next = {{PAD_W{1'b0}}, dc_reg & CSTRIM_DC_MASK};
         end else if (hit_zc) begin
            rd_next = {{PAD_W{1'b0}}, zc_reg & CSTRIM_ZC_MASK};
         end else begin
            rd_next = '0;
         end
      end
   end

   // Bus answer registers; each answer stands one cycle
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         rd_reg  <= '0;
      end else begin
         ack_reg <= ack_next;
         err_reg <= err_next;
         rd_reg  <= rd_next;
      end
   end

   // Outputs straight from flip-flops
   assign wb_ack_o                   = ack_reg;
   assign wb_err_o                   = err_reg;
   assign wb_dat_o                   = rd_reg;
   assign ac_gain_code_o             = ac_reg[3:0];
   assign dc_gain_code_o             = dc_reg[2:0];
   assign dc_gain_loop_enable_o      = dc_reg[CSTRIM_DC_EN_BIT];
   assign zero_current_offset_code_o = zc_reg;

   // Checks
   a_ac_top_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wb_ack_o && $past(hit_ac && !wb_we_i)) |-> wb_dat_o[DATA_W-1:7] == '0)
      else $error("AC gain bit 7 read as one");
   a_dc_gap_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      wb_ack_o |-> wb_dat_o[DATA_W-1:8] == '0 && !(($past(hit_dc)) && (|wb_dat_o[6:4])))
      else $error("DC gain bits 6..4 read as one");
   a_ac_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_b0 && hit_ac) |=> ac_gain_code_o == $past(wb_dat_i[3:0]))
      else $error("AC gain code not written");
   a_dc_code_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_b0 && hit_dc) |=> dc_gain_code_o == $past(wb_dat_i[2:0]))
      else $error("DC gain code not written");
   a_dc_en_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_b0 && hit_dc) |=> dc_gain_loop_enable_o == $past(wb_dat_i[7]))
      else $error("DC loop enable not written");
   a_en_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !(wr_b0 && hit_dc) |=> $stable(dc_gain_loop_enable_o) && $stable(dc_gain_code_o))
      else $error("DC gain field changed without a write");
   a_zc_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_b0 && hit_zc) |=> zero_current_offset_code_o == $past(wb_dat_i[7:0]))
      else $error("Offset code not written");
   a_ack_one: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("Ack held longer than one cycle");
   // Reserved storage bits keep what software wrote
   a_ac_rsvd_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_b0 && hit_ac) |=> ac_reg[6:4] == $past(wb_dat_i[6:4]) && !ac_reg[7])
      else $error("AC reserved bits not stored");
   a_dc_bit3_kept: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (wr_b0 && hit_dc) |=> dc_reg[3] == $past(wb_dat_i[3]) && dc_reg[6:4] == 3'h0)
      else $error("DC reserved bit not stored");
   // Refused and lane-less writes leave every register alone
   a_err_nowrite: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      wb_err_o |-> $stable(ac_reg) && $stable(dc_reg) && $stable(zc_reg))
      else $error("Register changed on a refused access");
   a_sel_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      (req && wb_we_i && !wb_sel_i[0]) |=> $stable(ac_reg) && $stable(dc_reg) && $stable(zc_reg))
      else $error("Register changed without lane 0 select");
   // Read data idles at zero between answers
   a_rd_idle_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
      !wb_ack_o |-> wb_dat_o == '0)
      else $error("Read data shown without ack");
   c_dc_disable: cover property (@(posedge clk_sys_i) $fell(dc_gain_loop_enable_o));
   c_ac_write: cover property (@(posedge clk_sys_i) wr_b0 && hit_ac);
   c_dc_enable: cover property (@(posedge clk_sys_i) $rose(dc_gain_loop_enable_o));
   c_zc_read: cover property (@(posedge clk_sys_i) req && hit_zc && !wb_we_i);
   c_unmapped: cover property (@(posedge clk_sys_i) wb_err_o);
endmodule // cstrim_regs

//--- tb/cstrim_tb.sv
/*
 Bench for the trim register bank: random Wishbone traffic against a model.
 Assumes the ack or err answer comes one cycle after a request is taken.
*/
`timescale 1ns/100ps
module testbench;
   import cstrim_pkg::*;
   logic        clk_sys_i, rst_b_i, cyc, stb, we, ack, err, en;
   logic [3:0]  adr, sel, ac;
   logic [31:0] wd, rd, q;
   logic [2:0]  dc;
   logic [7:0]  zc;
   logic [7:0]  mem [3];
   logic [7:0]  msk [3];
   logic        e;
   int          fail_count, total_checks, seed, i, k;
   // Device under test
   cstrim_regs dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .wb_err_o(err), .ac_gain_code_o(ac), .dc_gain_code_o(dc), .dc_gain_loop_enable_o(en),
      .zero_current_offset_code_o(zc));
   // Clock at 25 ns
   initial begin
      clk_sys_i = 0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
         fail_count++;
      end
   endtask
   // Verdict and end of run
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // One classic Wishbone cycle, held until ack or err
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1; stb <= 1; we <= w; adr <= a; wd <= d; sel <= s;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      if (n >= 20) chk(1, 0);
      q = rd;
      e = err;
      cyc <= 0; stb <= 0;
      @(posedge clk_sys_i);
   endtask
   // Watchdog
   initial begin
      #(25 * 20000);
      fail_count++;
      print_verdict();
   end
   // Main sequence
   initial begin
      {cyc, stb, we, adr, sel, wd} = '0;
      rst_b_i = 0;
      seed = 53141;
      mem = '{CSTRIM_AC_RST, CSTRIM_DC_RST, CSTRIM_ZC_RST};
      msk = '{CSTRIM_AC_MASK, CSTRIM_DC_MASK, CSTRIM_ZC_MASK};
      repeat (12) @(posedge clk_sys_i);
      rst_b_i <= 1;
      @(posedge clk_sys_i);
      bus(1, CSTRIM_ZC_OFS, 32'h80, 4'hF);
      for (i = 0; i < 200; i++) begin
         if (i == 100) begin
            // Mid-run reset: codes return to their reset values
            rst_b_i <= 0;
            @(posedge clk_sys_i);
            chk({ac, dc, en, zc}, {CSTRIM_AC_RST[3:0], CSTRIM_DC_RST[2:0], CSTRIM_DC_RST[7], CSTRIM_ZC_RST});
            mem = '{CSTRIM_AC_RST, CSTRIM_DC_RST, CSTRIM_ZC_RST};
            rst_b_i <= 1;
            @(posedge clk_sys_i);
         end
         k = (i < 3) ? i : {$random(seed)} % 4;
         bus((i < 3) ? 1'b0 : 1'($random(seed)), 4'(k * 4), $random(seed), 4'($random(seed)));
         chk(e, k == 3);
         if (k < 3 && we && sel[0]) mem[k] = wd[7:0] & msk[k];
         if (k < 3 && !we) chk(q, {24'h0, mem[k]});
         if (k == 3) chk(q, 32'h0);
         chk({ac, dc, en, zc}, {mem[0][3:0], mem[1][2:0], mem[1][7], mem[2]});
      end
      print_verdict();
   end
endmodule // testbench
